// file: fetch_sequencer.sv
// Instruction fetch pipeline, program counter and register file core
//
// Overview of operation
// [RULE1] Clock divided by four into ordered phases
// [RULE2] Program counter increments in phase one
// [RULE3] Instruction word captured in phase four
// [RULE4] Word enters instruction register in phase one
// [RULE5] Operand read phase two, destination write phase four
// [RULE6] Fetch overlaps execute, one cycle each
// [RULE7] Branches discard prefetch, take two cycles
// [RULE8] Small variant: 9-bit counter, 256 words wrap
// [RULE9] Large variant: 10-bit counter, 512 words wrap
// [RULE10] Execution starts at program address zero
// [RULE11] Software must keep last calibration word intact
// [RULE12] Small register file: 7 special, 16 general
// [RULE13] Large register file: 8 special, 24 general
// [RULE14] General registers reachable direct and via pointer
// [RULE15] Master clear pin resets device, active low
// [RULE16] Master clear forces weak pull-up on
// [RULE17] Input-only pin: optional pull-up and wake
// [RULE18] Reset restarts phases, fetch before execute
`timescale 1ns/1ps
`default_nettype none
module fetch_sequencer
  import fetch_core_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Program memory
  output logic [PC_WIDTH-1:0] o_program_address,
  input wire logic [INSTR_WIDTH-1:0] i_program_data,
  // Execute unit
  output logic [INSTR_WIDTH-1:0] o_instruction,
  output logic o_execute_valid,
  output logic o_flushing,
  output logic [DATA_WIDTH-1:0] o_operand,
  input wire logic [DATA_WIDTH-1:0] i_result,
  input wire logic i_result_write,
  input wire logic i_branch_request,
  input wire logic [PC_WIDTH-1:0] i_branch_target,
  // Phase outputs
  output logic o_phase_one,
  output logic o_phase_two,
  output logic o_phase_three,
  output logic o_phase_four,
  output logic o_quarter_clock_output,
  // Peripheral special function registers
  output logic [FILE_ADDR_WIDTH-1:0] o_sfr_address,
  output logic o_sfr_read,
  output logic o_sfr_write,
  output logic [DATA_WIDTH-1:0] o_sfr_write_data,
  input wire logic [DATA_WIDTH-1:0] i_sfr_read_data,
  output logic [DATA_WIDTH-1:0] o_indirect_address_pointer,
  // Shared master clear and input-only pin
  input wire logic i_master_clear_enable,
  input wire logic i_master_clear_input_n,
  input wire logic i_input_only_port_pin,
  input wire logic i_pullup_software_enable,
  input wire logic i_wake_enable,
  input wire logic i_sleeping,
  output logic o_device_reset_n,
  output logic o_pullup_enable,
  output logic o_pin_level,
  output logic o_wake_request
);

  typedef struct packed {
    logic [PC_WIDTH-1:0] pc;
    logic [PC_WIDTH-1:0] fetch_addr;
    logic [INSTR_WIDTH-1:0] fetch_word;
    logic fetch_valid;
    logic [INSTR_WIDTH-1:0] ir;
    logic ir_valid;
    logic flush;
    logic [DATA_WIDTH-1:0] operand;
    logic [DATA_WIDTH-1:0] pointer;
    logic [GPR_MAX-1:0][DATA_WIDTH-1:0] general_purpose_register;
    logic pin_level;
    logic wake;
  } core_state_type;

  core_state_type state;
  core_state_type next_state;
  phase_type phase;
  logic core_rst_n;
  logic [PC_WIDTH-1:0] pc_mask;
  logic [PC_WIDTH-1:0] impl_mask;
  logic [FILE_ADDR_WIDTH-1:0] sfr_count;
  logic [FILE_ADDR_WIDTH-1:0] gpr_base;
  logic [FILE_ADDR_WIDTH-1:0] data_addr;
  logic [FILE_ADDR_WIDTH-1:0] gpr_index;
  logic [DATA_WIDTH-1:0] read_value;

  // Keeps an address inside the given space; upper bits simply fold away
  function automatic logic [PC_WIDTH-1:0] wrap_addr(
    input logic [PC_WIDTH-1:0] addr,
    input logic [PC_WIDTH-1:0] mask
  );
    wrap_addr = addr & mask;
  endfunction : wrap_addr

  // Address zero selects the register named by the pointer
  function automatic logic [FILE_ADDR_WIDTH-1:0] effective_addr(
    input logic [INSTR_WIDTH-1:0] instr,
    input logic [DATA_WIDTH-1:0] pointer
  );
    logic [FILE_ADDR_WIDTH-1:0] field;
    field = instr[FILE_FIELD_LSB +: FILE_ADDR_WIDTH];
    if (field == INDIRECT_ADDR)
    begin
      effective_addr = pointer[FILE_ADDR_WIDTH-1:0]; // [RULE14]
    end
    else
    begin
      effective_addr = field; // [RULE14]
    end
  endfunction : effective_addr

  function automatic logic is_gpr(
    input logic [FILE_ADDR_WIDTH-1:0] addr,
    input logic [FILE_ADDR_WIDTH-1:0] base
  );
    is_gpr = (addr >= base);
  endfunction : is_gpr

  // Peripheral registers live outside; the pointer is held here
  function automatic logic is_outside_sfr(
    input logic [FILE_ADDR_WIDTH-1:0] addr,
    input logic [FILE_ADDR_WIDTH-1:0] count
  );
    is_outside_sfr = (addr != INDIRECT_ADDR) && (addr != POINTER_ADDR) &&
                     (addr < count);
  endfunction : is_outside_sfr

  // Master clear pulls the whole device into reset while configured
  assign core_rst_n = i_rst_n &
                      !(i_master_clear_enable && !i_master_clear_input_n); // [RULE15]

  quad_phase_gen phase_gen
  (
    .i_clock(i_clock),
    .i_rst_n(core_rst_n),
    .o_phase(phase),
    .o_quarter_clock(o_quarter_clock_output)
  );

  // Variant selection of counter width and register file layout
  always_comb
  begin
    if (LARGE_VARIANT)
    begin
      pc_mask = PC_MASK_LARGE; // [RULE9]
      impl_mask = IMPL_MASK_LARGE; // [RULE9]
      sfr_count = SFR_COUNT_LARGE; // [RULE13]
      gpr_base = GPR_BASE_LARGE; // [RULE13]
    end
    else
    begin
      pc_mask = PC_MASK_SMALL; // [RULE8]
      impl_mask = IMPL_MASK_SMALL; // [RULE8]
      sfr_count = SFR_COUNT_SMALL; // [RULE12]
      gpr_base = GPR_BASE_SMALL; // [RULE12]
    end
  end

  assign data_addr = effective_addr(state.ir, state.pointer);
  assign gpr_index = data_addr - gpr_base;

  // Data memory read source; unimplemented addresses read as zero
  always_comb
  begin
    if (is_gpr(data_addr, gpr_base))
    begin
      read_value = state.general_purpose_register[gpr_index];
    end
    else if (data_addr == POINTER_ADDR)
    begin
      read_value = state.pointer;
    end
    else if (is_outside_sfr(data_addr, sfr_count))
    begin
      read_value = i_sfr_read_data;
    end
    else
    begin
      read_value = 8'h00;
    end
  end

  always_comb
  begin
    next_state = state;
    next_state.wake = 1'b0;
    next_state.pin_level = i_input_only_port_pin;
    // Wake only on a level change while asleep and not used as clear
    if (i_sleeping && i_wake_enable && !i_master_clear_enable &&
        (i_input_only_port_pin != state.pin_level))
    begin
      next_state.wake = 1'b1; // [RULE17]
    end
    case (phase)
      PHASE_ONE:
      begin
        // Current counter value is the address fetched this cycle
        next_state.fetch_addr = wrap_addr(state.pc, impl_mask); // [RULE8]
        next_state.pc = wrap_addr(state.pc + 10'h001, pc_mask); // [RULE2]
        next_state.ir = state.fetch_word; // [RULE4]
        // A word prefetched behind a branch never executes
        next_state.ir_valid = state.fetch_valid && !state.flush; // [RULE7]
        next_state.flush = 1'b0;
      end
      PHASE_TWO:
      begin
        if (state.ir_valid)
        begin
          next_state.operand = read_value; // [RULE5]
        end
      end
      PHASE_THREE:
      begin
        next_state.operand = state.operand;
      end
      PHASE_FOUR:
      begin
        next_state.fetch_word = i_program_data; // [RULE3]
        next_state.fetch_valid = 1'b1; // [RULE6]
        if (state.ir_valid && i_result_write)
        begin
          if (is_gpr(data_addr, gpr_base))
          begin
            next_state.general_purpose_register[gpr_index] = i_result; // [RULE5]
          end
          else if (data_addr == POINTER_ADDR)
          begin
            next_state.pointer = i_result; // [RULE14]
          end
        end
        if (state.ir_valid && i_branch_request)
        begin
          next_state.pc = wrap_addr(i_branch_target, pc_mask); // [RULE7]
          next_state.flush = 1'b1; // [RULE7]
        end
      end
      default:
      begin
        next_state.flush = state.flush;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!core_rst_n)
    begin
      state.pc <= RESET_VECTOR; // [RULE10]
      state.fetch_addr <= RESET_VECTOR;
      state.fetch_word <= 12'h000;
      state.fetch_valid <= 1'b0; // [RULE18]
      state.ir <= 12'h000;
      state.ir_valid <= 1'b0; // [RULE18]
      state.flush <= 1'b0;
      state.operand <= 8'h00;
      state.pointer <= POINTER_RESET;
      state.general_purpose_register <= '0;
      state.pin_level <= 1'b0;
      state.wake <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Program memory and execute unit
  assign o_program_address = state.fetch_addr;
  assign o_instruction = state.ir;
  assign o_execute_valid = state.ir_valid;
  assign o_flushing = state.flush;
  assign o_operand = state.operand;

  // Phase strobes
  assign o_phase_one = (phase == PHASE_ONE);
  assign o_phase_two = (phase == PHASE_TWO);
  assign o_phase_three = (phase == PHASE_THREE);
  assign o_phase_four = (phase == PHASE_FOUR);

  // Peripheral registers see the same read and write phases as the file
  assign o_sfr_address = data_addr;
  assign o_sfr_read = state.ir_valid && (phase == PHASE_TWO) &&
                      is_outside_sfr(data_addr, sfr_count); // [RULE5]
  assign o_sfr_write = state.ir_valid && i_result_write &&
                       (phase == PHASE_FOUR) &&
                       is_outside_sfr(data_addr, sfr_count); // [RULE5]
  assign o_sfr_write_data = i_result;
  assign o_indirect_address_pointer = state.pointer;

  // Shared pin
  assign o_device_reset_n = core_rst_n; // [RULE15]
  assign o_pullup_enable = i_master_clear_enable ||
                           i_pullup_software_enable; // [RULE16]
  assign o_pin_level = state.pin_level; // [RULE17]
  assign o_wake_request = state.wake; // [RULE17]

endmodule : fetch_sequencer
`default_nettype wire

// file: fetch_core_pkg.sv
// Shared constants and types for the instruction sequencing core
package fetch_core_pkg;

  // Instruction cycle made of quadrature phases
  localparam int PHASES_PER_CYCLE = 4;
  typedef enum logic [1:0]
  {
    PHASE_ONE = 2'b00,
    PHASE_TWO = 2'b01,
    PHASE_THREE = 2'b10,
    PHASE_FOUR = 2'b11
  } phase_type;

  // Widths
  localparam int PC_WIDTH = 10;
  localparam int INSTR_WIDTH = 12;
  localparam int DATA_WIDTH = 8;
  localparam int FILE_ADDR_WIDTH = 5;
  localparam int GPR_MAX = 24;

  // Program counter width and implemented program space per variant
  localparam logic [9:0] PC_MASK_SMALL = 10'h1ff;
  localparam logic [9:0] PC_MASK_LARGE = 10'h3ff;
  localparam logic [9:0] IMPL_MASK_SMALL = 10'h0ff;
  localparam logic [9:0] IMPL_MASK_LARGE = 10'h1ff;
  localparam logic [9:0] RESET_VECTOR = 10'h000;

  // Register file layout per variant
  localparam logic [4:0] SFR_COUNT_SMALL = 5'h07;
  localparam logic [4:0] SFR_COUNT_LARGE = 5'h08;
  localparam logic [4:0] GPR_BASE_SMALL = 5'h10;
  localparam logic [4:0] GPR_BASE_LARGE = 5'h08;
  localparam logic [4:0] INDIRECT_ADDR = 5'h00;
  localparam logic [4:0] POINTER_ADDR = 5'h04;
  localparam logic [7:0] POINTER_RESET = 8'he0;

  // Instruction field holding the register file address
  localparam int FILE_FIELD_LSB = 0;

endpackage : fetch_core_pkg

// file: quad_phase_gen.sv
// Divide-by-four phase generator with quarter-rate clock output
`timescale 1ns/1ps
`default_nettype none
module quad_phase_gen
  import fetch_core_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Phase outputs
  output var phase_type o_phase,
  output logic o_quarter_clock
);

  typedef struct packed {
    phase_type phase;
    logic quarter;
  } phase_state_type;

  phase_state_type state;
  phase_state_type next_state;

  always_comb
  begin
    next_state = state;
    case (state.phase)
      PHASE_ONE: next_state.phase = PHASE_TWO;
      PHASE_TWO: next_state.phase = PHASE_THREE;
      PHASE_THREE: next_state.phase = PHASE_FOUR;
      PHASE_FOUR: next_state.phase = PHASE_ONE;
      default: next_state.phase = PHASE_ONE;
    endcase
    // Quarter clock is high for the first half of each instruction cycle
    next_state.quarter = (next_state.phase == PHASE_ONE) ||
                         (next_state.phase == PHASE_TWO);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state.phase <= PHASE_ONE; // [RULE18]
      state.quarter <= 1'b1;
    end
    else
    begin
      state <= next_state; // [RULE1]
    end
  end

  assign o_phase = state.phase;
  assign o_quarter_clock = state.quarter;

endmodule : quad_phase_gen
`default_nettype wire

// file: fetch_core_checker.sv
// Port-level assertions for the fetch sequencer
`timescale 1ns/1ps
`default_nettype none
module fetch_core_checker
  import fetch_core_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic o_device_reset_n,
  // Fetch and execute
  input wire logic [PC_WIDTH-1:0] o_program_address,
  input wire logic [INSTR_WIDTH-1:0] i_program_data,
  input wire logic [INSTR_WIDTH-1:0] o_instruction,
  input wire logic o_execute_valid,
  input wire logic o_flushing,
  input wire logic i_result_write,
  input wire logic i_branch_request,
  input wire logic o_sfr_read,
  input wire logic o_sfr_write,
  input wire logic [FILE_ADDR_WIDTH-1:0] o_sfr_address,
  // Phases
  input wire logic o_phase_one,
  input wire logic o_phase_two,
  input wire logic o_phase_three,
  input wire logic o_phase_four,
  input wire logic o_quarter_clock_output
);
  // Fetches wrap inside the implemented space, not the counter's range
  localparam logic [PC_WIDTH-1:0] FMASK =
    LARGE_VARIANT ? IMPL_MASK_LARGE : IMPL_MASK_SMALL;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!o_device_reset_n);

  AST_PHASE: assert property (o_phase_one |=> o_phase_two ##1
    o_phase_three ##1 o_phase_four ##1 o_phase_one)
    else $error("phase order broken");
  AST_ONEHOT: assert property ($onehot({o_phase_one, o_phase_two,
    o_phase_three, o_phase_four})) else $error("phases overlap");
  AST_QCLK: assert property (o_quarter_clock_output ==
    (o_phase_one || o_phase_two)) else $error("quarter clock wrong");
  AST_ADDR_STEP: assert property (o_phase_two && o_execute_valid
    |-> o_program_address == (($past(o_program_address, 4) + 10'h001)
    & FMASK)) else $error("fetch address did not step");
  AST_IR_LOAD: assert property (o_phase_two && o_execute_valid
    |-> o_instruction == $past(i_program_data, 2))
    else $error("instruction not the phase four word");
  AST_IR_HOLD: assert property ((o_phase_three || o_phase_four)
    |-> $stable(o_instruction) && $stable(o_execute_valid))
    else $error("instruction changed mid cycle");
  // Valid only drops at the phase one edge after the branch is taken
  AST_BRANCH: assert property (o_phase_four && o_execute_valid &&
    i_branch_request |=> o_flushing ##1
    (!o_execute_valid)[*4] ##1 o_execute_valid)
    else $error("branch did not cost two cycles");
  AST_SFR_RD: assert property (o_sfr_read |->
    o_phase_two && o_execute_valid) else $error("read outside phase two");
  AST_SFR_WR: assert property (o_sfr_write |-> o_phase_four &&
    o_execute_valid && i_result_write)
    else $error("write outside phase four");
  AST_SFR_HIT: assert property (o_sfr_address == 5'h01 &&
    o_phase_two && o_execute_valid |-> o_sfr_read)
    else $error("peripheral read missed");
endmodule : fetch_core_checker

bind fetch_sequencer fetch_core_checker #(.LARGE_VARIANT(LARGE_VARIANT))
  u_checker (.i_clock, .o_device_reset_n, .o_program_address,
  .i_program_data, .o_instruction, .o_execute_valid, .o_flushing,
  .i_result_write, .i_branch_request, .o_sfr_read, .o_sfr_write,
  .o_sfr_address, .o_phase_one, .o_phase_two, .o_phase_three,
  .o_phase_four, .o_quarter_clock_output);
`default_nettype wire

// file: prog_mem_model.sv
// Program memory array model: read-only words with a settling delay
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
  import fetch_core_pkg::*;
#(
  parameter int SETTLE = 1
)
(
  input wire logic i_clock,
  input wire logic [PC_WIDTH-1:0] i_address,
  output logic [INSTR_WIDTH-1:0] o_data
);
  logic [PC_WIDTH-1:0] last = '0;
  int age = 0;
  always @(posedge i_clock)
  begin
    age <= (i_address != last) ? 0 : age + 1;
    last <= i_address;
  end
  // Unsettled output shows the inverse so a too-early sample is caught
  always_comb
  begin
    if (i_address != last || age < SETTLE)
      o_data = ~{2'b01, i_address};
    else
      o_data = {2'b01, i_address};
  end
endmodule : prog_mem_model
`default_nettype wire

// file: instruction_fetch_pipeline_memory_map_tb.sv
// Self-checking bench for the fetch sequencer
`timescale 1ns/1ps
`default_nettype none
module instruction_fetch_pipeline_memory_map_tb
  import fetch_core_pkg::*;
  ;
  logic i_clock = 1'b0, i_rst_n = 1'b0;
  logic i_result_write = 1'b0, i_branch_request = 1'b0;
  logic [DATA_WIDTH-1:0] i_result = '0;
  logic [PC_WIDTH-1:0] i_branch_target = '0;
  logic i_master_clear_enable = 1'b0, i_master_clear_input_n = 1'b1;
  logic i_input_only_port_pin = 1'b0, i_pullup_software_enable = 1'b0;
  logic i_wake_enable = 1'b0, i_sleeping = 1'b0;
  logic [PC_WIDTH-1:0] o_program_address;
  logic [INSTR_WIDTH-1:0] i_program_data, o_instruction;
  logic [DATA_WIDTH-1:0] o_operand, o_indirect_address_pointer;
  logic [FILE_ADDR_WIDTH-1:0] o_sfr_address;
  logic o_execute_valid, o_flushing, o_phase_one, o_phase_two;
  logic o_phase_four, o_device_reset_n, o_pullup_enable;
  logic o_pin_level, o_wake_request;
  logic [PC_WIDTH-1:0] large_program_address;
  logic [INSTR_WIDTH-1:0] large_program_data, large_instruction;
  logic [DATA_WIDTH-1:0] large_operand;
  int mismatches = 0, total_checks = 0, cycles = 0, t0;

  fetch_sequencer #(.LARGE_VARIANT(1'b0)) DUT (
    .i_clock, .i_rst_n, .o_program_address, .i_program_data,
    .o_instruction, .o_execute_valid, .o_flushing, .o_operand, .i_result,
    .i_result_write, .i_branch_request, .i_branch_target, .o_phase_one,
    .o_phase_two, .o_phase_three(), .o_phase_four,
    .o_quarter_clock_output(), .o_sfr_address, .o_sfr_read(),
    .o_sfr_write(), .o_sfr_write_data(), .i_sfr_read_data(8'h3c),
    .o_indirect_address_pointer, .i_master_clear_enable,
    .i_master_clear_input_n, .i_input_only_port_pin,
    .i_pullup_software_enable, .i_wake_enable, .i_sleeping,
    .o_device_reset_n, .o_pullup_enable, .o_pin_level, .o_wake_request);
  prog_mem_model #(.SETTLE(1)) u_mem (.i_clock,
    .i_address(o_program_address), .o_data(i_program_data));

  // Larger variant runs in lockstep on the same stimulus
  fetch_sequencer #(.LARGE_VARIANT(1'b1)) DUT_LARGE (
    .i_clock, .i_rst_n, .o_program_address(large_program_address),
    .i_program_data(large_program_data),
    .o_instruction(large_instruction), .o_execute_valid(),
    .o_flushing(), .o_operand(large_operand), .i_result,
    .i_result_write, .i_branch_request, .i_branch_target,
    .o_phase_one(), .o_phase_two(), .o_phase_three(), .o_phase_four(),
    .o_quarter_clock_output(), .o_sfr_address(), .o_sfr_read(),
    .o_sfr_write(), .o_sfr_write_data(), .i_sfr_read_data(8'h3c),
    .o_indirect_address_pointer(), .i_master_clear_enable,
    .i_master_clear_input_n, .i_input_only_port_pin,
    .i_pullup_software_enable, .i_wake_enable, .i_sleeping,
    .o_device_reset_n(), .o_pullup_enable(), .o_pin_level(),
    .o_wake_request());
  prog_mem_model #(.SETTLE(1)) u_mem_large (.i_clock,
    .i_address(large_program_address), .o_data(large_program_data));

  always #5 i_clock = ~i_clock;

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // Generous ceiling: the whole sequence needs well under 300 cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [11:0] word(input logic [9:0] a);
    return {2'b01, a};
  endfunction : word

  task automatic to_ph4;
    @(negedge i_clock);
    while (!(o_phase_four === 1'b1 && o_execute_valid === 1'b1))
      @(negedge i_clock);
  endtask : to_ph4

  // Result and branch presented in phase four, withdrawn a clock later
  task automatic drive(input logic w, input logic [7:0] d,
    input logic b, input logic [9:0] t);
    i_result_write = w;
    i_result = d;
    i_branch_request = b;
    i_branch_target = t;
    @(negedge i_clock);
    i_result_write = 1'b0;
    i_branch_request = 1'b0;
  endtask : drive

  task automatic t_start;
    repeat (6) @(negedge i_clock);
    chk(o_phase_one === 1'b1 && o_program_address === '0, "rst");
    i_rst_n = 1'b1;
    @(negedge i_clock);
    chk(o_phase_two === 1'b1, "phase after release");
    to_ph4;
    chk(o_instruction === word('0), "first word");
    chk(large_instruction === word('0), "large first word");
    $display("t_start done");
  endtask : t_start

  task automatic t_seq;
    for (int i = 1; i < 4; i++)
    begin
      t0 = cycles;
      drive(1'b1, 8'h5a, 1'b0, '0);
      to_ph4;
      chk(cycles - t0 == 4, "not one cycle");
      chk(o_instruction === word(10'(i)), "word");
      chk(o_program_address === 10'(i + 1), "pc step");
    end
    $display("t_seq done");
  endtask : t_seq

  task automatic t_branch;
    t0 = cycles;
    drive(1'b0, 8'h00, 1'b1, 10'h3fe);
    chk(o_flushing === 1'b1, "no flush");
    to_ph4;
    chk(cycles - t0 == 8, "branch cost");
    chk(o_instruction === word(10'h0fe), "target");
    chk(o_program_address === 10'h0ff, "last word");
    chk(large_instruction === word(10'h1fe), "large target");
    chk(large_program_address === 10'h1ff, "large last word");
    to_ph4;
    chk(o_program_address === 10'h000, "wrap");
    chk(large_program_address === 10'h000, "large wrap");
    $display("t_branch done");
  endtask : t_branch

  task automatic t_data;
    drive(1'b0, 8'h00, 1'b1, 10'h010);
    to_ph4;
    drive(1'b1, 8'h5c, 1'b1, 10'h004);
    to_ph4;
    drive(1'b1, 8'h10, 1'b1, 10'h020);
    chk(o_indirect_address_pointer === 8'h10, "pointer");
    to_ph4;
    chk(o_sfr_address === 5'h10, "indirect address");
    chk(o_operand === 8'h5c, "indirect read");
    chk(large_operand === 8'h5c, "large indirect read");
    drive(1'b0, 8'h00, 1'b1, 10'h00f);
    to_ph4;
    chk(o_operand === 8'h00, "gap reads zero");
    drive(1'b1, 8'h77, 1'b0, '0);
    to_ph4;
    chk(o_operand === 8'h5c, "direct read");
    drive(1'b0, 8'h00, 1'b1, 10'h00f);
    to_ph4;
    chk(o_operand === 8'h00, "gap write dropped");
    chk(large_operand === 8'h77, "large general read");
    drive(1'b0, 8'h00, 1'b1, 10'h007);
    to_ph4;
    chk(o_operand === 8'h00, "eighth address unused");
    chk(large_operand === 8'h3c, "eighth special read");
    drive(1'b0, 8'h00, 1'b1, 10'h001);
    to_ph4;
    chk(o_operand === 8'h3c, "sfr read");
    chk(large_operand === 8'h3c, "large sfr read");
    $display("t_data done");
  endtask : t_data

  task automatic t_pin;
    i_sleeping = 1'b1;
    i_wake_enable = 1'b1;
    i_input_only_port_pin = 1'b1;
    @(negedge i_clock);
    chk(o_wake_request === 1'b1 && o_pin_level === 1'b1, "wake");
    @(negedge i_clock);
    chk(o_wake_request === 1'b0, "wake pulse");
    chk(o_pullup_enable === 1'b0, "pull-up off");
    i_pullup_software_enable = 1'b1;
    #1;
    chk(o_pullup_enable === 1'b1, "software pull-up");
    i_pullup_software_enable = 1'b0;
    i_master_clear_enable = 1'b1;
    i_master_clear_input_n = 1'b0;
    #1;
    chk(o_device_reset_n === 1'b0, "clear");
    chk(o_pullup_enable === 1'b1, "forced pull-up");
    repeat (3) @(negedge i_clock);
    chk(o_phase_one === 1'b1 && o_program_address === '0, "held");
    i_master_clear_input_n = 1'b1;
    to_ph4;
    chk(o_instruction === word('0), "restart");
    chk(large_instruction === word('0), "large restart");
    $display("t_pin done");
  endtask : t_pin

  initial
  begin
    t_start();
    t_seq();
    t_branch();
    t_data();
    t_pin();
    close_out();
  end
endmodule : instruction_fetch_pipeline_memory_map_tb
`default_nettype wire
